// ==== common/vic_pkg.sv ====
package vic_pkg;
  localparam int NUM_LINES = 8;
  localparam int IDX_W = 3;
  localparam int SYNC_STAGES = 3;

  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_MASK_BIT = 8'h0c;
  localparam logic [7:0] ADDR_LATCH = 8'h10;
  localparam logic [7:0] ADDR_EV_STS = 8'h18;
  localparam logic [7:0] ADDR_EV_MSK = 8'h1c;
  localparam logic [7:0] ADDR_RESP_BASE = 8'h20;
  localparam logic [7:0] ADDR_RESP_LAST = 8'h3c;

  // mode register fields
  localparam int MODE_PRIO_BIT = 0;
  localparam int MODE_COMMON_BIT = 1;
  localparam int MODE_POLL_BIT = 2;
  localparam int MODE_RESTART_BIT = 3;
  localparam int MODE_ARM_BIT = 7;

  // single-bit mask write fields
  localparam int MBIT_IDX_LSB = 0;
  localparam int MBIT_VAL_BIT = 3;

  // status register fields
  localparam int STS_ARM_BIT = 3;
  localparam int STS_POLL_BIT = 4;
  localparam int STS_ROT_BIT = 5;
  localparam int STS_GROUP_BIT = 7;

  // event bits
  localparam int EV_W = 2;
  localparam int EV_REQ_BIT = 0;
  localparam int EV_SVC_BIT = 1;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] RESP_RST = 8'h00;
  localparam logic [IDX_W-1:0] COMMON_LINE = 3'h7;
endpackage : vic_pkg

// ==== common/prio_if.sv ====
`timescale 1ns/1ps
interface prio_if;
  logic [vic_pkg::NUM_LINES-1:0] pend;
  logic rotating;
  logic [vic_pkg::IDX_W-1:0] last_srv;
  logic any;
  logic [vic_pkg::IDX_W-1:0] top;

  modport resolver (input pend, input rotating, input last_srv, output any, output top);
  modport user (output pend, output rotating, output last_srv, input any, input top);
endinterface : prio_if

// ==== design/req_capture.sv ====
`timescale 1ns/1ps
module req_capture #(
  parameter int LINES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [LINES-1:0] req_n,
  output logic [LINES-1:0] level
);
  logic [LINES-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [LINES-1:0] lvl_d;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      // a change needs two agreeing samples; one-cycle spikes never reach lvl
      always_comb begin
        lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= ~req_n[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          lvl_q[g] <= lvl_d[g];
        end
      end

      chk_glitch_reject: assert property (@(posedge clk_sys) disable iff (!rst_n)
          $rose(lvl_q[g]) |-> $past(s2_q[g]) && $past(s3_q[g]))
        else $error("request accepted without two agreeing samples");
    end
  endgenerate

  assign level = lvl_q;
endmodule : req_capture

// ==== design/prio_resolve.sv ====
`timescale 1ns/1ps
module prio_resolve (
  prio_if.resolver bus
);
  logic [vic_pkg::IDX_W-1:0] base;
  logic [vic_pkg::IDX_W-1:0] idx;
  logic found;

  // search downward from the highest position; rotating starts just below last serviced
  always_comb begin
    base = bus.rotating ? bus.last_srv - 3'h1 : 3'h7;
    found = 1'b0;
    bus.top = 3'h0;
    idx = 3'h0;
    for (int i = 0; i < vic_pkg::NUM_LINES; i++) begin
      idx = base - i[vic_pkg::IDX_W-1:0];
      if (!found && bus.pend[idx]) begin
        found = 1'b1;
        bus.top = idx;
      end
    end
    bus.any = found;
  end
endmodule : prio_resolve

// ==== design/vectored_interrupt_controller.sv ====
`timescale 1ns/1ps
// Operation
// - eight bus request lines are captured, prioritised and vectored.
// - the mask can be written as a whole byte or one chosen bit at a time.
// - captured requests catch both short pulses and steady levels but drop narrow spikes.
// - priority among simultaneous requests is fixed or rotating by software choice.
// - software can select a polled mode that bypasses the vectoring answer.
// - in restart mode any programmed byte is returned unchanged for any request.
// - in table mode one vector byte is returned as the low half of a table pointer.
// - a table-mode vector always has its least significant bit cleared.
// - a captured request is held until it is serviced or cleared by software.
// - any latched unmasked request raises the group interrupt while the mode register's arm bit is set and its poll bit is clear.
// - on acknowledge the highest pending request's response byte (line 7's in common mode) goes on the data bus.
// - setup goes through a command register and state is read from a status register.
// - fixed priority has line 7 highest; rotating makes the last serviced line lowest.
// - the poll bit selects polled operation with the group interrupt held off.
module vectored_interrupt_controller (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [vic_pkg::NUM_LINES-1:0] vi_n,
  input wire logic inta_n,
  output logic grp_int_n,
  output logic [7:0] vec_o,
  output logic vec_oe,
  output logic irq
);
  typedef enum logic [0:0] {ACK_IDLE, ACK_HOLD} ack_state_e;

  localparam int N = vic_pkg::NUM_LINES;

  function automatic logic is_resp(input logic [7:0] adr);
    is_resp = (adr >= vic_pkg::ADDR_RESP_BASE) && (adr <= vic_pkg::ADDR_RESP_LAST)
              && (adr[1:0] == 2'h0);
  endfunction : is_resp

  logic [N-1:0] req_lvl;
  logic ack_lvl;
  logic [7:0] mode_q, mode_d;
  logic [N-1:0] mask_q, mask_d;
  logic [N-1:0] latch_q, latch_d;
  logic [vic_pkg::IDX_W-1:0] last_q, last_d;
  logic [7:0] resp_q [N];
  logic [7:0] resp_d [N];
  logic [vic_pkg::EV_W-1:0] ev_sts_q, ev_sts_d, ev_msk_q, ev_msk_d, ev_set;
  logic irq_q, irq_d;
  logic grp_int_n_q, grp_int_n_d;
  logic [7:0] vec_q, vec_d;
  logic vec_oe_q, vec_oe_d;
  ack_state_e ack_st_q, ack_st_d;
  logic wb_ack_q, wb_ack_d;
  logic [31:0] wb_dat_q, wb_dat_d;

  logic bus_req, bus_wr;
  logic rotating, common, poll, restart, armed;
  logic ack_rise, service;
  logic [N-1:0] sw_clr, svc_clr;
  logic [vic_pkg::IDX_W-1:0] resp_line;
  logic [7:0] resp_byte, status, rd_data;

  req_capture #(.LINES(N)) u_req (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req_n(vi_n),
    .level(req_lvl)
  );

  req_capture #(.LINES(1)) u_ack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req_n(inta_n),
    .level(ack_lvl)
  );

  prio_if u_pif ();
  prio_resolve u_prio (
    .bus(u_pif.resolver)
  );

  assign rotating = mode_q[vic_pkg::MODE_PRIO_BIT];
  assign common = mode_q[vic_pkg::MODE_COMMON_BIT];
  assign poll = mode_q[vic_pkg::MODE_POLL_BIT];
  assign restart = mode_q[vic_pkg::MODE_RESTART_BIT];
  assign armed = mode_q[vic_pkg::MODE_ARM_BIT];

  // disarmed behaves as if every mask bit were set
  assign u_pif.pend = latch_q & ~mask_q & {N{armed}};
  assign u_pif.rotating = rotating;
  assign u_pif.last_srv = last_q;

  // polled mode answers no acknowledge; requests stay latched for software
  assign ack_rise = ack_lvl && (ack_st_q == ACK_IDLE);
  assign service = ack_rise && !poll && u_pif.any;

  // common vectoring always answers with line 7's entry (COMMON_LINE), whatever line is on top
  assign resp_line = common ? vic_pkg::COMMON_LINE : u_pif.top;

  always_comb begin
    resp_byte = resp_q[resp_line];
    if (!restart) begin
      resp_byte[0] = 1'b0;
    end
  end

  assign status = {u_pif.any, 1'b0, rotating, poll, armed, ~u_pif.top};

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  always_comb begin
    rd_data = 8'h00;
    case (wb_adr_i)
      vic_pkg::ADDR_MODE: rd_data = mode_q;
      vic_pkg::ADDR_STATUS: rd_data = status;
      vic_pkg::ADDR_MASK: rd_data = mask_q;
      vic_pkg::ADDR_LATCH: rd_data = latch_q;
      vic_pkg::ADDR_EV_STS: rd_data = {6'h00, ev_sts_q};
      vic_pkg::ADDR_EV_MSK: rd_data = {6'h00, ev_msk_q};
      default: begin
        if (is_resp(wb_adr_i)) begin
          rd_data = resp_q[wb_adr_i[4:2]];
        end
      end
    endcase
  end

  // register writes
  always_comb begin
    mode_d = mode_q;
    mask_d = mask_q;
    sw_clr = '0;
    ev_msk_d = ev_msk_q;
    for (int i = 0; i < N; i++) begin
      resp_d[i] = resp_q[i];
    end
    if (bus_wr) begin
      case (wb_adr_i)
        vic_pkg::ADDR_MODE: mode_d = wb_dat_i[7:0];
        vic_pkg::ADDR_MASK: mask_d = wb_dat_i[7:0];
        vic_pkg::ADDR_MASK_BIT: begin
          mask_d[wb_dat_i[vic_pkg::MBIT_IDX_LSB +: vic_pkg::IDX_W]] =
            wb_dat_i[vic_pkg::MBIT_VAL_BIT];
        end
        vic_pkg::ADDR_LATCH: sw_clr = wb_dat_i[N-1:0];
        vic_pkg::ADDR_EV_MSK: ev_msk_d = wb_dat_i[vic_pkg::EV_W-1:0];
        default: begin
          if (is_resp(wb_adr_i)) begin
            resp_d[wb_adr_i[4:2]] = wb_dat_i[7:0];
          end
        end
      endcase
    end
  end

  // request latch: a new capture beats a clear in the same cycle
  always_comb begin
    svc_clr = '0;
    if (service) begin
      svc_clr[u_pif.top] = 1'b1;
    end
    latch_d = (latch_q & ~(sw_clr | svc_clr)) | req_lvl;
  end

  // acknowledge sequence
  always_comb begin
    ack_st_d = ack_st_q;
    vec_d = vec_q;
    vec_oe_d = vec_oe_q;
    last_d = last_q;
    case (ack_st_q)
      ACK_IDLE: begin
        if (ack_rise) begin
          ack_st_d = ACK_HOLD;
          vec_d = resp_byte;
          vec_oe_d = !poll;
          if (service) begin
            last_d = u_pif.top;
          end
        end
      end
      ACK_HOLD: begin
        if (!ack_lvl) begin
          ack_st_d = ACK_IDLE;
          vec_oe_d = 1'b0;
        end
      end
      default: begin
        ack_st_d = ACK_IDLE;
        vec_oe_d = 1'b0;
      end
    endcase
  end

  // group interrupt is active low toward the processor
  always_comb begin
    grp_int_n_d = !(u_pif.any && !poll);
  end

  // sticky events, write one to clear; a same-cycle event wins
  always_comb begin
    ev_set = '0;
    ev_set[vic_pkg::EV_REQ_BIT] = |(req_lvl & ~latch_q);
    ev_set[vic_pkg::EV_SVC_BIT] = service;
    ev_sts_d = ev_sts_q;
    if (bus_wr && (wb_adr_i == vic_pkg::ADDR_EV_STS)) begin
      ev_sts_d = ev_sts_q & ~wb_dat_i[vic_pkg::EV_W-1:0];
    end
    ev_sts_d = ev_sts_d | ev_set;
    irq_d = |(ev_sts_q & ev_msk_q);
  end

  // every access is answered in the next cycle, unmapped ones read zero
  always_comb begin
    wb_ack_d = bus_req;
    wb_dat_d = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      wb_dat_d = {24'h00_0000, rd_data};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= vic_pkg::MODE_RST;
      mask_q <= vic_pkg::MASK_RST;
      latch_q <= '0;
      last_q <= vic_pkg::COMMON_LINE;
      for (int i = 0; i < N; i++) begin
        resp_q[i] <= vic_pkg::RESP_RST;
      end
      ev_sts_q <= '0;
      ev_msk_q <= '0;
      irq_q <= 1'b0;
      grp_int_n_q <= 1'b1;
      vec_q <= 8'h00;
      vec_oe_q <= 1'b0;
      ack_st_q <= ACK_IDLE;
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      mode_q <= mode_d;
      mask_q <= mask_d;
      latch_q <= latch_d;
      last_q <= last_d;
      for (int i = 0; i < N; i++) begin
        resp_q[i] <= resp_d[i];
      end
      ev_sts_q <= ev_sts_d;
      ev_msk_q <= ev_msk_d;
      irq_q <= irq_d;
      grp_int_n_q <= grp_int_n_d;
      vec_q <= vec_d;
      vec_oe_q <= vec_oe_d;
      ack_st_q <= ack_st_d;
      wb_ack_q <= wb_ack_d;
      wb_dat_q <= wb_dat_d;
    end
  end

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;
  assign grp_int_n = grp_int_n_q;
  assign vec_o = vec_q;
  assign vec_oe = vec_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_mask_byte_write: assert property (
    bus_wr && wb_adr_i == vic_pkg::ADDR_MASK |=> mask_q == $past(wb_dat_i[7:0]))
    else $error("byte mask write not stored");

  chk_mask_single_bit: assert property (
    bus_wr && wb_adr_i == vic_pkg::ADDR_MASK_BIT
    |=> mask_q[$past(wb_dat_i[2:0])] == $past(wb_dat_i[3])
        && (mask_q | (8'h01 << $past(wb_dat_i[2:0])))
           == ($past(mask_q) | (8'h01 << $past(wb_dat_i[2:0]))))
    else $error("single-bit mask write wrong");

  chk_latch_holds: assert property (
    !service && !(bus_wr && wb_adr_i == vic_pkg::ADDR_LATCH)
    |=> (latch_q & $past(latch_q)) == $past(latch_q))
    else $error("latched request lost without service");

  chk_group_raised: assert property (
    (|(latch_q & ~mask_q)) && armed && !poll |=> !grp_int_n)
    else $error("group interrupt not raised for pending request");

  chk_poll_quiet: assert property (
    poll ##1 poll |-> grp_int_n)
    else $error("group interrupt active in polled mode");

  chk_table_vec_even: assert property (
    ack_rise && !restart && !poll |=> vec_oe ##0 !vec_o[0])
    else $error("table vector has odd low bit");

  chk_vec_entry: assert property (
    service && !common |=> vec_oe && vec_o[7:1] == $past(resp_q[u_pif.top][7:1]))
    else $error("wrong response byte on acknowledge");

  chk_fixed_top: assert property (
    !rotating && u_pif.pend[7] |-> u_pif.top == 3'h7)
    else $error("fixed priority does not favour line 7");

  // the nested condition is a plain boolean; a sequence cannot be joined to a property
  chk_rotate_lowest: assert property (
    service && rotating && latch_q[u_pif.top] && req_lvl == '0
    |=> last_q == $past(u_pif.top)
        && (!u_pif.any || u_pif.pend == (8'h01 << last_q) || u_pif.top != last_q))
    else $error("last serviced line not lowest under rotation");

  chk_poll_no_drive: assert property (
    ack_rise && poll |=> !vec_oe [*2])
    else $error("vector driven in polled mode");

  chk_group_idle: assert property (
    !((|(latch_q & ~mask_q)) && armed && !poll) |=> grp_int_n)
    else $error("group interrupt active with nothing unmasked pending");

  chk_fixed_low: assert property (
    !rotating && u_pif.pend[0] && u_pif.pend[7:1] != 7'h00 |-> u_pif.top != 3'h0)
    else $error("fixed priority does not leave line 0 lowest");

  chk_capture_held: assert property (
    req_lvl != '0 |=> (latch_q & $past(req_lvl)) == $past(req_lvl))
    else $error("accepted request not latched");

  // a request still held at the pin relatches, so only a released one must clear
  chk_service_clears: assert property (
    service && !req_lvl[u_pif.top] |=> !latch_q[$past(u_pif.top)])
    else $error("serviced request still latched");

  chk_vec_idle_off: assert property (
    ack_st_q == ACK_IDLE |-> !vec_oe)
    else $error("vector driven outside acknowledge");
endmodule : vectored_interrupt_controller

// ==== test/cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic fixed_call,
  input wire logic [7:0] hold,
  input wire logic vec_oe,
  input wire logic [7:0] vec_o,
  output logic inta_n,
  output logic done,
  output logic [15:0] ptr
);
  // table page register, arbitrary value
  localparam logic [7:0] PAGE = 8'h5a;
  // fixed call target of the processor's fixed-call mode
  localparam logic [15:0] FIXED_CALL = 16'h0066;
  int n;
  // one process owns every output of the model
  initial begin
    inta_n = 1'b1;
    done = 1'b0;
    ptr = 16'h0000;
    forever begin
      @(posedge clk_sys);
      if (go === 1'b1 && rst_n === 1'b1) begin
        inta_n <= 1'b0;
        n = 0;
        while (vec_oe !== 1'b1 && n < 20) begin
          @(posedge clk_sys);
          n++;
        end
        if (fixed_call === 1'b1) begin
          ptr <= FIXED_CALL;
        end else begin
          // vector is the low byte of the table pointer
          ptr <= (vec_oe === 1'b1) ? {PAGE, vec_o} : 16'hffff;
        end
        repeat (hold) @(posedge clk_sys);
        inta_n <= 1'b1;
        n = 0;
        while (vec_oe !== 1'b0 && n < 20) begin
          @(posedge clk_sys);
          n++;
        end
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
      end
    end
  end
endmodule : cpu_model

// ==== test/vectored_interrupt_controller_tb.sv ====
`timescale 1ns/1ps
module vectored_interrupt_controller_tb;
  logic clk_sys, rst_n, cyc, stb, we, inta_n, grp_int_n, vec_oe, irq, ack, go, done;
  logic [7:0] adr, vi_n, vec_o, hold;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] ptr;
  logic fixed_call;
  int mismatches, n_compared;
  typedef struct {logic [7:0] mode; logic [7:0] pat; logic [2:0] top; logic [7:0] vec;} row_s;
  row_s rows[4];

  vectored_interrupt_controller u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .vi_n(vi_n), .inta_n(inta_n), .grp_int_n(grp_int_n),
    .vec_o(vec_o), .vec_oe(vec_oe), .irq(irq));
  cpu_model u_cpu (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .fixed_call(fixed_call),
    .hold(hold), .vec_oe(vec_oe), .vec_o(vec_o), .inta_n(inta_n), .done(done), .ptr(ptr));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) mismatches++;
  endtask : wb

  // lines in p held low for c cycles, then time for the filter and latch
  task automatic req(input logic [7:0] p, input int c);
    @(posedge clk_sys);
    vi_n <= ~p;
    repeat (c) @(posedge clk_sys);
    vi_n <= 8'hff;
    repeat (8) @(posedge clk_sys);
  endtask : req

  task automatic acknowledge;
    int n;
    n = 0;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 60);
    if (n >= 60) mismatches++;
  endtask : acknowledge

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, go, fixed_call} = 5'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat_i = 32'h0;
    vi_n = 8'hff;
    hold = 8'h02;
    mismatches = 0;
    n_compared = 0;
    rows[0] = '{8'h80, 8'h05, 3'h2, 8'hd6};
    rows[1] = '{8'h88, 8'h81, 3'h7, 8'hff};
    rows[2] = '{8'h88, 8'h01, 3'h0, 8'hc7};
    rows[3] = '{8'h82, 8'h03, 3'h1, 8'hfe};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check(grp_int_n, 1);
    wb(0, vic_pkg::ADDR_MASK, 0);
    check(q, 32'hff);
    wb(0, vic_pkg::ADDR_MODE, 0);
    check(q, 32'h00);
    wb(0, 8'h40, 0);
    check(q, 32'h00);
    for (int k = 0; k < 8; k++) wb(1, vic_pkg::ADDR_RESP_BASE + 8'(4 * k), 32'(8'hc7 + 8 * k));
    wb(1, vic_pkg::ADDR_MASK, 0);
    foreach (rows[i]) begin
      wb(1, vic_pkg::ADDR_MODE, rows[i].mode);
      req(rows[i].pat, 6);
      check(grp_int_n, 0);
      wb(0, vic_pkg::ADDR_STATUS, 0);
      check(q, {2'b10, rows[i].mode[0], rows[i].mode[2], 1'b1, ~rows[i].top});
      acknowledge();
      check(ptr, {8'h5a, rows[i].vec});
      wb(0, vic_pkg::ADDR_LATCH, 0);
      check(q, rows[i].pat & ~(8'h01 << rows[i].top));
      wb(1, vic_pkg::ADDR_LATCH, 32'hff);
    end
    // narrow spike dropped, wider pulse caught and held
    wb(1, vic_pkg::ADDR_MODE, 8'h80);
    req(8'h08, 1);
    wb(0, vic_pkg::ADDR_LATCH, 0);
    check(q, 32'h00);
    req(8'h08, 3);
    wb(0, vic_pkg::ADDR_LATCH, 0);
    check(q, 32'h08);
    wb(1, vic_pkg::ADDR_LATCH, 32'hff);
    wb(1, vic_pkg::ADDR_MASK, 32'hff);
    wb(1, vic_pkg::ADDR_MASK_BIT, 32'h04);
    wb(0, vic_pkg::ADDR_MASK, 0);
    check(q, 32'hef);
    req(8'h08, 3);
    check(grp_int_n, 1);
    req(8'h10, 3);
    check(grp_int_n, 0);
    wb(1, vic_pkg::ADDR_LATCH, 32'hff);
    wb(1, vic_pkg::ADDR_MASK, 0);
    // polled: no group interrupt, acknowledge leaves latch alone
    wb(1, vic_pkg::ADDR_MODE, 8'h84);
    req(8'h01, 3);
    check(grp_int_n, 1);
    acknowledge();
    check(ptr, 16'hffff);
    wb(0, vic_pkg::ADDR_LATCH, 0);
    check(q, 32'h01);
    wb(1, vic_pkg::ADDR_LATCH, 32'hff);
    // last serviced is line 1, so line 0 outranks line 7
    wb(1, vic_pkg::ADDR_MODE, 8'h81);
    req(8'h81, 3);
    acknowledge();
    check(ptr, 16'h5ac6);
    acknowledge();
    check(ptr, 16'h5afe);
    wb(1, vic_pkg::ADDR_EV_STS, 32'h03);
    wb(1, vic_pkg::ADDR_EV_MSK, 32'h01);
    req(8'h20, 3);
    check(irq, 1);
    wb(1, vic_pkg::ADDR_EV_STS, 32'h01);
    repeat (2) @(posedge clk_sys);
    check(irq, 0);
    wb(1, vic_pkg::ADDR_EV_MSK, 32'h00);
    req(8'h40, 3);
    check(irq, 0);
    wb(0, vic_pkg::ADDR_EV_STS, 0);
    check(q, 32'h01);
    // fixed-call mode ignores the vector; line 6 is still serviced below last line 7
    fixed_call <= 1'b1;
    acknowledge();
    check(ptr, 16'h0066);
    fixed_call <= 1'b0;
    wb(0, vic_pkg::ADDR_LATCH, 0);
    check(q, 32'h20);
    wb(0, vic_pkg::ADDR_EV_STS, 0);
    check(q, 32'h03);
    // reset in mid-run drops the pending line 5 and all settings
    check(grp_int_n, 0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(grp_int_n, 1);
    check(vec_oe, 0);
    check(irq, 0);
    rst_n <= 1'b1;
    wb(0, vic_pkg::ADDR_MASK, 0);
    check(q, 32'hff);
    wb(0, vic_pkg::ADDR_LATCH, 0);
    check(q, 32'h00);
    print_verdict();
  end
endmodule : vectored_interrupt_controller_tb
